// ---- verilog/xie_xor_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Top nibble 1111: XOR accumulator with literal
// - Literal result to accumulator only; zero flag
// - 0001 10df ffff: XOR accumulator with file
// - d=0: result to accumulator; zero updated
// - d=1: result to file; accumulator kept
module xie_xor_exec
	import xie_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire xie_instr_t instr_in,
	input wire logic [7:0] file_rdata_in,
	output logic [4:0] file_raddr_out,
	output var xie_fwr_t file_wr_out,
	output logic [7:0] acc_out,
	output logic zero_out,
	output logic zero_we_out,
	output logic busy_out
);
	// One-hot class of the issued word
	typedef enum logic [2:0] {
		XIE_NONE = 3'b001,
		XIE_LIT = 3'b010,
		XIE_FILE = 3'b100
	} xie_kind_t;

	// Classify a 12-bit word by its opcode bits
	function automatic xie_kind_t xie_decode(input logic [11:0] w);
		if (w[11:8] == XIE_OP_LIT) begin
			return XIE_LIT;
		end
		if (w[11:6] == XIE_OP_FILE) begin
			return XIE_FILE;
		end
		return XIE_NONE;
	endfunction

	// Zero test shared by flag logic and checks
	function automatic logic xie_is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	// Datapath nets and state
	xie_kind_t kind;
	logic [7:0] operand;
	logic [7:0] result;
	logic dest_file;
	logic [7:0] acc_r;
	logic zero_r;
	xie_fwr_t fwr_r;
	logic zwe_r;
	// Destination strobes for this cycle
	logic acc_load;
	logic file_load;
	logic flag_load;

	// Decode and combine
	always_comb begin
		kind = instr_in.valid ? xie_decode(instr_in.word) : XIE_NONE;
		dest_file = instr_in.word[XIE_DBIT];
		operand = 8'h00;
		case (kind)
			XIE_LIT: operand = instr_in.word[7:0];
			XIE_FILE: operand = file_rdata_in;
			default: operand = 8'h00;
		endcase
		result = acc_r ^ operand;
	end

	// Read address straight from the word; never stalls
	assign file_raddr_out = instr_in.word[4:0];
	assign busy_out = 1'b0;

	// Steer the result: accumulator, file or neither
	always_comb begin
		acc_load = 1'b0;
		file_load = 1'b0;
		flag_load = 1'b0;
		case (kind)
			XIE_LIT: begin
				acc_load = 1'b1;
				flag_load = 1'b1;
			end
			XIE_FILE: begin
				acc_load = !dest_file;
				file_load = dest_file;
				flag_load = 1'b1;
			end
			default: begin
				acc_load = 1'b0;
				file_load = 1'b0;
				flag_load = 1'b0;
			end
		endcase
	end

	// Accumulator update
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc_r <= XIE_W_RST;
		end else if (acc_load) begin
			acc_r <= result;
		end
	end

	// Zero flag
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			zero_r <= XIE_Z_RST;
			zwe_r <= 1'b0;
		end else begin
			zwe_r <= flag_load;
			if (flag_load) begin
				zero_r <= xie_is_zero(result);
			end
		end
	end

	// File write-back
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fwr_r <= '0;
		end else begin
			fwr_r.we <= file_load;
			fwr_r.addr <= instr_in.word[4:0];
			fwr_r.data <= result;
		end
	end

	// Registered outputs
	assign acc_out = acc_r;
	assign zero_out = zero_r;
	assign zero_we_out = zwe_r;
	assign file_wr_out = fwr_r;

	// Assertions below are all disabled while reset is held
	// Literal xor lands in the accumulator
	lit_acc_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_LIT |=> acc_r == ($past(acc_r) ^ $past(instr_in.word[7:0])))
		else $error("literal xor wrong");

	// Literal xor never writes the file, always strobes the flag
	lit_nofile_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_LIT |=> !fwr_r.we && zwe_r)
		else $error("literal xor touched file");

	// Zero flag follows whichever result was stored
	zero_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind != XIE_NONE |=> zero_r == xie_is_zero(fwr_r.we ? fwr_r.data : acc_r))
		else $error("zero flag wrong");

	// File xor with d=0 updates the accumulator
	file_acc_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_FILE && !dest_file |=> acc_r == ($past(acc_r) ^ $past(file_rdata_in)))
		else $error("file xor to acc wrong");

	// File xor with d=0 leaves the file alone
	file_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_FILE && !dest_file |=> !fwr_r.we && zwe_r)
		else $error("file xor wrote file");

	// File xor with d=1 writes back and keeps the accumulator
	file_back_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_FILE && dest_file |=> fwr_r.we && $stable(acc_r)
		&& fwr_r.addr == $past(instr_in.word[4:0])
		&& fwr_r.data == ($past(acc_r) ^ $past(file_rdata_in)))
		else $error("file write-back wrong");

	// Write strobe only follows a d=1 file xor
	we_source_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		fwr_r.we |-> $past(kind == XIE_FILE) && $past(dest_file))
		else $error("stray file write");

	// Flag strobe only follows an xor
	zwe_source_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		zwe_r |-> $past(kind != XIE_NONE))
		else $error("stray flag strobe");

	// Never asks the decoder to stall
	no_stall_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!busy_out)
		else $error("stall raised");

	// Idle cycles keep the accumulator and drop both strobes
	idle_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_NONE |=> $stable(acc_r) && !fwr_r.we && !zwe_r)
		else $error("idle changed state");

	// Idle cycles keep the zero flag
	idle_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_NONE |=> $stable(zero_r))
		else $error("idle changed zero flag");

	// A valid word of another instruction is ignored
	refuse_word_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		instr_in.valid && kind == XIE_NONE |=> $stable(acc_r) && !zwe_r)
		else $error("foreign word executed");

	// A word not issued changes nothing
	valid_low_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!instr_in.valid |=> $stable(acc_r) && $stable(zero_r) && !zwe_r && !fwr_r.we)
		else $error("unissued word executed");

	// Back to back literals forward the accumulator
	back_to_back_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_LIT ##1 kind == XIE_LIT |=> acc_r == ($past(acc_r, 2)
		^ $past(instr_in.word[7:0], 2) ^ $past(instr_in.word[7:0])))
		else $error("back to back lost");

	// Literal then write-back uses the forwarded accumulator
	lit_file_fwd_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		kind == XIE_LIT ##1 (kind == XIE_FILE && dest_file) |=> fwr_r.we
		&& fwr_r.data == ($past(acc_r, 2) ^ $past(instr_in.word[7:0], 2)
		^ $past(file_rdata_in)))
		else $error("forwarding into file lost");

	// Main scenarios reached
	lit_c: cover property (@(posedge clk_sys_in) kind == XIE_LIT);
	file_w_c: cover property (@(posedge clk_sys_in) kind == XIE_FILE && !dest_file);
	file_f_c: cover property (@(posedge clk_sys_in) kind == XIE_FILE && dest_file);
	zero_c: cover property (@(posedge clk_sys_in) kind != XIE_NONE && result == 8'h00);
	b2b_c: cover property (@(posedge clk_sys_in) kind == XIE_LIT ##1 kind == XIE_LIT);
endmodule // xie_xor_exec
`default_nettype wire

// ---- verilog/xie_pkg.sv ----
`default_nettype none
package xie_pkg;
	localparam int XIE_DW = 8;
	localparam int XIE_IW = 12;
	localparam int XIE_FA = 5;
	// Opcode patterns
	localparam logic [3:0] XIE_OP_LIT = 4'hF;
	localparam logic [5:0] XIE_OP_FILE = 6'h06;
	localparam int XIE_DBIT = 5;
	localparam logic [7:0] XIE_W_RST = 8'h00;
	localparam logic XIE_Z_RST = 1'b0;
	// Instruction issue from decoder
	typedef struct packed {
		logic valid;
		logic [11:0] word;
	} xie_instr_t;
	// Write-back toward register file
	typedef struct packed {
		logic we;
		logic [4:0] addr;
		logic [7:0] data;
	} xie_fwr_t;
endpackage
`default_nettype wire

// ---- testbench/xie_file_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Register file behind the core
module xie_file_model
	import xie_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic [4:0] addr_in,
	input wire xie_fwr_t wr_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem_r [32];
	// Preload each cell with its address
	initial for (int i = 0; i < 32; i++) mem_r[i] = 8'(i);
	assign rdata_out = mem_r[addr_in];
	// Commit write-back strobe
	always @(posedge clk_sys_in) if (wr_in.we) mem_r[wr_in.addr] <= wr_in.data;
endmodule // xie_file_model
`default_nettype wire

// ---- testbench/xor_instruction_execute_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("FAIL %0t bad value", $time); end end
module xor_instruction_execute_test
	import xie_pkg::*;
;
	logic clk_sys_in = 0, rstn_in = 0, zero_out, zero_we_out, busy_out;
	xie_instr_t instr = '0;
	xie_fwr_t wr;
	logic [7:0] rdata, acc_out;
	logic [4:0] raddr;
	int errors = 0, tests_run = 0;
	always #12.5 clk_sys_in = ~clk_sys_in;
	xie_xor_exec DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .instr_in(instr),
		.file_rdata_in(rdata), .file_raddr_out(raddr), .file_wr_out(wr), .acc_out(acc_out),
		.zero_out(zero_out), .zero_we_out(zero_we_out), .busy_out(busy_out));
	xie_file_model FM (.clk_sys_in(clk_sys_in), .addr_in(raddr), .wr_in(wr), .rdata_out(rdata));
	// Issue one word, judge the cycle after
	task op(input logic [11:0] w, input logic [7:0] a, input logic z, input logic x, input logic we);
		@(posedge clk_sys_in) instr <= {1'b1, w};
		@(posedge clk_sys_in) instr <= '0;
		#1;
		`CHK(acc_out, a)
		`CHK(zero_out, z)
		`CHK(zero_we_out, x)
		`CHK(wr.we, we)
		`CHK(busy_out, 1'b0)
	endtask
	// Literal forms, including a zero result
	task lit_s;
		op(12'hFB5, 8'hB5, 1'b0, 1'b1, 1'b0);
		op(12'hFAF, 8'h1A, 1'b0, 1'b1, 1'b0);
		op(12'hF1A, 8'h00, 1'b1, 1'b1, 1'b0);
	endtask
	// File forms at top and bottom address, both destinations
	task file_s;
		op(12'hFB5, 8'hB5, 1'b0, 1'b1, 1'b0);
		op(12'h1BF, 8'hB5, 1'b0, 1'b1, 1'b1);
		`CHK(wr.addr, 5'h1F)
		`CHK(wr.data, 8'hAA)
		op(12'h19F, 8'h1F, 1'b0, 1'b1, 1'b0);
		op(12'h180, 8'h1F, 1'b0, 1'b1, 1'b0);
		op(12'h19F, 8'hB5, 1'b0, 1'b1, 1'b0);
	endtask
	// Other words leave state alone
	task refuse_s;
		op(12'h7FF, 8'hB5, 1'b0, 1'b0, 1'b0);
		op(12'h1FF, 8'hB5, 1'b0, 1'b0, 1'b0);
		@(posedge clk_sys_in) instr <= {1'b0, 12'hF55};
		@(posedge clk_sys_in) instr <= '0;
		#1;
		`CHK(acc_out, 8'hB5)
		`CHK(zero_we_out, 1'b0)
	endtask
	// Back to back issue forwards the accumulator
	task b2b_s;
		@(posedge clk_sys_in) instr <= {1'b1, 12'hF0F};
		@(posedge clk_sys_in) instr <= {1'b1, 12'hF33};
		#1;
		`CHK(acc_out, 8'hBA)
		@(posedge clk_sys_in) instr <= {1'b1, 12'h1A5};
		#1;
		`CHK(acc_out, 8'h89)
		@(posedge clk_sys_in) instr <= '0;
		#1;
		`CHK(acc_out, 8'h89)
		`CHK(wr.we, 1'b1)
		`CHK(wr.addr, 5'h05)
		`CHK(wr.data, 8'h8C)
		`CHK(zero_we_out, 1'b1)
	endtask
	// Mid-run reset, then a zero write-back
	task rst_s;
		@(posedge clk_sys_in) rstn_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		`CHK(acc_out, 8'h00)
		`CHK(zero_out, 1'b0)
		`CHK(zero_we_out, 1'b0)
		`CHK(wr.we, 1'b0)
		@(posedge clk_sys_in) rstn_in <= 1'b1;
		op(12'h1A0, 8'h00, 1'b1, 1'b1, 1'b1);
		`CHK(wr.addr, 5'h00)
		`CHK(wr.data, 8'h00)
	endtask
	task results;
		if (errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Reset, then scenarios
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		lit_s();
		file_s();
		refuse_s();
		b2b_s();
		rst_s();
		results();
	end
endmodule // xor_instruction_execute_test
`default_nettype wire
